// *** src/rct_defs.svh ***
// Offsets, field positions and reset values for the RC trim register block
`ifndef RCT_DEFS_SVH
`define RCT_DEFS_SVH
`define RCT_IDX_TRIM_HIGH 12'h2F8
`define RCT_IDX_TRIM_LOW 12'h2F9
`define RCT_ADDR_TRIM_HIGH 14'h0BE0
`define RCT_ADDR_TRIM_LOW 14'h0BE4
`define RCT_ADDR_CTRL 14'h0BE8
`define RCT_ADDR_STATUS 14'h0BEC
`define RCT_TC_MSB 15
`define RCT_TC_LSB 12
`define RCT_FREQ_MSB 9
`define RCT_FREQ_LSB 0
`define RCT_COARSE_LSB 6
`define RCT_HIGH_WMASK 8'hF3
`define RCT_TRIM_RESET 16'h0000
`define RCT_TC_OFF_A 4'h0
`define RCT_TC_OFF_B 4'h8
`define RCT_RESP_OKAY 2'h0
`define RCT_RESP_SLVERR 2'h2
`endif

// *** src/rct_pkg.sv ***
// Types for the RC trim register block
package rct_pkg;
  typedef struct packed {
    logic [13:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [13:0] araddr;
    logic arvalid;
    logic rready;
  } rct_axi_req_t;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rct_axi_rsp_t;
  typedef struct packed {
    logic enable;
    logic negative;
    logic [2:0] step;
  } rct_tc_ctrl_t;
  typedef enum logic [1:0] {
    LOAD_IDLE,
    LOAD_WAIT,
    LOAD_RUN
  } rct_load_t;
endpackage

// *** src/rct_tc_decode.sv ***
// Decode of the temperature-coefficient trim code
`timescale 1ns/1ps
`include "rct_defs.svh"
module rct_tc_decode (
  input wire logic [3:0] tcCode, // Trim code
  output rct_pkg::rct_tc_ctrl_t tcCtrl // Compensation control
);
  import rct_pkg::*;
  always_comb begin
    // Both codes switch compensation off
    tcCtrl.enable = (tcCode != `RCT_TC_OFF_A) && (tcCode != `RCT_TC_OFF_B);
    tcCtrl.negative = ~tcCode[3];
    tcCtrl.step = tcCode[2:0];
  end
endmodule

// *** src/rct_trim_regs.sv ***
// RC oscillator trim register pair with AXI4-Lite slave
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
`include "rct_defs.svh"
// Contract
// - Load factory trim from flash after reset
// - Writes ignored while protection is set
// - Write with PLL selected clears flags
// - Tempco trim in bits 15 to 12
// - Codes 0000 and 1000 disable compensation
// - Low codes negative, high codes positive
// - Bits 9..6 coarse frequency trim
// - Bits 5..0 fine frequency trim
module rct_trim_regs (
  input wire logic core_clk, // Bus clock
  input wire logic rst, // Synchronous reset, active high
  input rct_pkg::rct_axi_req_t axiReq, // AXI4-Lite requests
  output rct_pkg::rct_axi_rsp_t axiRsp, // AXI4-Lite responses
  input wire logic clockConfigProtect, // Protection bit, same clock
  input wire logic pllClockSelect, // PLL is system clock, same clock
  output logic flagClear, // Pulse clearing lock and osc qualified flags
  output logic flashLoadReq, // Request for factory trim fetch
  input wire logic flashLoadValid, // Factory trim word is valid
  input wire logic [15:0] flashLoadData, // Factory trim word
  output logic [3:0] tempcoTrim, // Tempco trim field
  output rct_pkg::rct_tc_ctrl_t tcCtrl, // Decoded compensation control
  output logic [3:0] coarseTrim, // Coarse frequency trim
  output logic [5:0] fineTrim, // Fine frequency trim
  output logic trimReady // Factory trim is in place
);
  import rct_pkg::*;

  typedef struct packed {
    logic [15:0] trim;
    rct_load_t load;
    logic awHeld;
    logic [13:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic flagClr;
  } rct_state_t;

  rct_state_t state_ff;
  rct_state_t nxt_state;
  logic [13:0] wAddr;
  logic doWrite;
  logic hiHit;
  logic loHit;
  logic [31:0] wd;
  logic [3:0] ws;

  // ==========================================================
  // Next state
  always_comb begin
    nxt_state = state_ff;
    nxt_state.flagClr = 1'b0;
    wAddr = state_ff.awHeld ? state_ff.awAddr : axiReq.awaddr;
    // Data may arrive before, together with or after the address
    wd = state_ff.wHeld ? state_ff.wData : axiReq.wdata;
    ws = state_ff.wHeld ? state_ff.wStrb : axiReq.wstrb;
    // Factory load runs once after reset release
    case (state_ff.load)
      LOAD_IDLE: begin
        nxt_state.load = LOAD_WAIT;
      end
      LOAD_WAIT: begin
        if (flashLoadValid) begin
          nxt_state.trim = flashLoadData & 16'hF3FF;
          nxt_state.load = LOAD_RUN;
        end
      end
      LOAD_RUN: begin
        nxt_state.load = LOAD_RUN;
      end
      default: begin
        nxt_state.load = LOAD_IDLE;
      end
    endcase
    if (axiReq.awvalid && !state_ff.awHeld && !state_ff.bValid) begin
      nxt_state.awHeld = 1'b1;
      nxt_state.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && !state_ff.wHeld && !state_ff.bValid) begin
      nxt_state.wHeld = 1'b1;
      nxt_state.wData = axiReq.wdata;
      nxt_state.wStrb = axiReq.wstrb;
    end
    doWrite = (state_ff.awHeld || axiReq.awvalid) && (state_ff.wHeld || axiReq.wvalid)
      && !state_ff.bValid;
    hiHit = wAddr[13:2] == `RCT_ADDR_TRIM_HIGH >> 2;
    loHit = wAddr[13:2] == `RCT_ADDR_TRIM_LOW >> 2;
    if (doWrite) begin
      nxt_state.awHeld = 1'b0;
      nxt_state.wHeld = 1'b0;
      nxt_state.bValid = 1'b1;
      nxt_state.bResp = (hiHit || loHit) ? `RCT_RESP_OKAY : `RCT_RESP_SLVERR;
      if ((hiHit || loHit) && ws[0] && !clockConfigProtect && state_ff.load == LOAD_RUN) begin
        if (hiHit) begin
          nxt_state.trim[15:8] = wd[7:0] & `RCT_HIGH_WMASK;
        end else begin
          nxt_state.trim[7:0] = wd[7:0];
        end
        nxt_state.flagClr = pllClockSelect;
      end
    end
    if (state_ff.bValid && axiReq.bready) begin
      nxt_state.bValid = 1'b0;
    end
    if (axiReq.arvalid && !state_ff.rValid) begin
      nxt_state.rValid = 1'b1;
      nxt_state.rResp = `RCT_RESP_OKAY;
      case (axiReq.araddr[13:2])
        `RCT_ADDR_TRIM_HIGH >> 2: nxt_state.rData = {24'h000000, state_ff.trim[15:8]};
        `RCT_ADDR_TRIM_LOW >> 2: nxt_state.rData = {24'h000000, state_ff.trim[7:0]};
        default: begin
          nxt_state.rData = 32'h00000000;
          nxt_state.rResp = `RCT_RESP_SLVERR;
        end
      endcase
    end else if (state_ff.rValid && axiReq.rready) begin
      nxt_state.rValid = 1'b0;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================================
  // Outputs
  rct_tc_decode uDecode (
    .tcCode(state_ff.trim[`RCT_TC_MSB:`RCT_TC_LSB]),
    .tcCtrl(tcCtrl)
  );

  always_comb begin
    axiRsp.awready = !state_ff.awHeld && !state_ff.bValid;
    axiRsp.wready = !state_ff.wHeld && !state_ff.bValid;
    axiRsp.bvalid = state_ff.bValid;
    axiRsp.bresp = state_ff.bResp;
    axiRsp.arready = !state_ff.rValid;
    axiRsp.rvalid = state_ff.rValid;
    axiRsp.rdata = state_ff.rData;
    axiRsp.rresp = state_ff.rResp;
  end

  assign flagClear = state_ff.flagClr;
  assign flashLoadReq = state_ff.load == LOAD_WAIT;
  assign trimReady = state_ff.load == LOAD_RUN;
  assign tempcoTrim = state_ff.trim[`RCT_TC_MSB:`RCT_TC_LSB];
  assign coarseTrim = state_ff.trim[`RCT_FREQ_MSB:`RCT_COARSE_LSB];
  assign fineTrim = state_ff.trim[`RCT_COARSE_LSB-1:`RCT_FREQ_LSB];

  // ==========================================================
  // Checks
  sequence wrTrimSeq;
    doWrite && (hiHit || loHit) && ws[0] && !clockConfigProtect && trimReady;
  endsequence

  clock_config_protect_block_a: assert property (@(posedge core_clk) disable iff (rst)
    (doWrite && clockConfigProtect && !flashLoadValid) |=> $stable(state_ff.trim))
    else $error("trim changed while protected");
  flag_clear_a: assert property (@(posedge core_clk) disable iff (rst)
    flagClear |-> $past(doWrite) && $past(pllClockSelect) && !$past(clockConfigProtect))
    else $error("flag clear without qualifying write");
  flag_need_a: assert property (@(posedge core_clk) disable iff (rst)
    (wrTrimSeq ##0 pllClockSelect) |=> flagClear)
    else $error("flag clear missing");
  load_fill_a: assert property (@(posedge core_clk) disable iff (rst)
    (flashLoadReq && flashLoadValid) |=> trimReady && state_ff.trim == ($past(flashLoadData) & 16'hF3FF))
    else $error("factory trim not loaded");
  load_start_a: assert property (@(posedge core_clk) disable iff (rst)
    $fell(rst) |-> ##[0:2] flashLoadReq || trimReady)
    else $error("factory load not requested");
  tc_field_a: assert property (@(posedge core_clk) disable iff (rst)
    tempcoTrim == state_ff.trim[15:12])
    else $error("tempco field misplaced");
  tc_off_a: assert property (@(posedge core_clk) disable iff (rst)
    (tempcoTrim[2:0] == 3'h0) |-> !tcCtrl.enable)
    else $error("compensation not disabled");
  tc_sign_a: assert property (@(posedge core_clk) disable iff (rst)
    (tempcoTrim[2:0] != 3'h0) |-> tcCtrl.enable && (tcCtrl.negative == !tempcoTrim[3]))
    else $error("compensation sign wrong");
  freq_split_a: assert property (@(posedge core_clk) disable iff (rst)
    {coarseTrim, fineTrim} == state_ff.trim[9:0])
    else $error("frequency trim split wrong");
  fine_keep_a: assert property (@(posedge core_clk) disable iff (rst)
    (trimReady && !doWrite) |=> $stable(fineTrim))
    else $error("fine trim changed without write");
  unimpl_zero_a: assert property (@(posedge core_clk) disable iff (rst)
    state_ff.trim[11:10] == 2'h0)
    else $error("unimplemented bits set");
endmodule

// *** verification/rct_trim_regs_bench.sv ***
// Self-checking bench for the RC trim register pair
`timescale 1ns/1ps
`include "rct_defs.svh"
module rct_trim_regs_bench;
  import rct_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  rct_axi_req_t axiReq = '0;
  rct_axi_rsp_t axiRsp;
  logic clockConfigProtect = 1'b0;
  logic pllClockSelect = 1'b0;
  logic flagClear, flashLoadReq, trimReady;
  logic flashLoadValid = 1'b0;
  logic [15:0] flashLoadData = 16'hFFFF;
  logic [3:0] tempcoTrim, coarseTrim;
  logic [5:0] fineTrim;
  rct_tc_ctrl_t tcCtrl;
  logic [15:0] trimModel = 16'h0000;
  int miscompares = 0;
  int checked = 0;
  // Rows: address, write byte, expected read byte, expected response
  logic [31:0] rows [5] = '{{`RCT_ADDR_TRIM_HIGH, 8'hFF, 8'hF3, `RCT_RESP_OKAY},
    {`RCT_ADDR_TRIM_LOW, 8'h00, 8'h00, `RCT_RESP_OKAY},
    {`RCT_ADDR_TRIM_HIGH, 8'h0C, 8'h00, `RCT_RESP_OKAY},
    {`RCT_ADDR_TRIM_LOW, 8'hC0, 8'hC0, `RCT_RESP_OKAY},
    {14'h0004, 8'hAA, 8'h00, `RCT_RESP_SLVERR}};

  always #12.5 core_clk = ~core_clk;

  rct_trim_regs dut (.core_clk(core_clk), .rst(rst), .axiReq(axiReq), .axiRsp(axiRsp),
    .clockConfigProtect(clockConfigProtect), .pllClockSelect(pllClockSelect),
    .flagClear(flagClear), .flashLoadReq(flashLoadReq), .flashLoadValid(flashLoadValid),
    .flashLoadData(flashLoadData), .tempcoTrim(tempcoTrim), .tcCtrl(tcCtrl),
    .coarseTrim(coarseTrim), .fineTrim(fineTrim), .trimReady(trimReady));

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %0h seen %0h", n, e, g);
    end
  endtask

  task automatic wr(input logic [13:0] a, input logic [7:0] d, input logic [1:0] er,
                    input logic apply);
    logic aw, w, clr, awr, wrr, bv;
    logic [1:0] r, br;
    aw = 1'b1;
    w = 1'b1;
    clr = 1'b0;
    r = 2'h3;
    axiReq.awaddr <= a;
    axiReq.awvalid <= 1'b1;
    axiReq.wdata <= {24'h000000, d};
    axiReq.wstrb <= 4'hF;
    axiReq.wvalid <= 1'b1;
    axiReq.bready <= 1'b1;
    for (int i = 0; i < 100; i++) begin
      // Settled values, which stand at the next rising edge
      @(negedge core_clk);
      awr = axiRsp.awready === 1'b1;
      wrr = axiRsp.wready === 1'b1;
      bv = axiRsp.bvalid === 1'b1;
      br = axiRsp.bresp;
      if (flagClear === 1'b1) clr = 1'b1;
      @(posedge core_clk);
      if (aw && awr) begin
        axiReq.awvalid <= 1'b0;
        aw = 1'b0;
      end
      if (w && wrr) begin
        axiReq.wvalid <= 1'b0;
        w = 1'b0;
      end
      if (bv) begin
        r = br;
        break;
      end
    end
    axiReq.bready <= 1'b0;
    @(posedge core_clk);
    chk("bresp", er, r);
    chk("flagClear", apply & pllClockSelect, clr);
    if (apply && a == `RCT_ADDR_TRIM_HIGH) trimModel[15:8] = d & 8'hF3;
    if (apply && a == `RCT_ADDR_TRIM_LOW) trimModel[7:0] = d;
    chk("tempcoTrim", trimModel[15:12], tempcoTrim);
    chk("coarseTrim", trimModel[9:6], coarseTrim);
    chk("fineTrim", trimModel[5:0], fineTrim);
  endtask

  task automatic rd(input logic [13:0] a, input logic [7:0] e, input logic [1:0] er);
    logic [31:0] d, rdv;
    logic [1:0] r, rrv;
    logic arr, rv;
    d = 32'hFFFFFFFF;
    r = 2'h3;
    axiReq.araddr <= a;
    axiReq.arvalid <= 1'b1;
    axiReq.rready <= 1'b1;
    for (int i = 0; i < 100; i++) begin
      @(negedge core_clk);
      arr = axiRsp.arready === 1'b1;
      rv = axiRsp.rvalid === 1'b1;
      rdv = axiRsp.rdata;
      rrv = axiRsp.rresp;
      @(posedge core_clk);
      if (axiReq.arvalid && arr) axiReq.arvalid <= 1'b0;
      if (rv) begin
        d = rdv;
        r = rrv;
        break;
      end
    end
    axiReq.rready <= 1'b0;
    @(posedge core_clk);
    chk("rdata", {24'h000000, e}, d);
    chk("rresp", er, r);
  endtask

  task automatic close_out();
    $display("Counts: checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    logic [3:0] code;
    repeat (16) @(posedge core_clk);
    chk("trimReady", 1'b0, trimReady);
    chk("flashLoadReq", 1'b0, flashLoadReq);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("flashLoadReq", 1'b1, flashLoadReq);
    // Too early: answered but not applied
    wr(`RCT_ADDR_TRIM_LOW, 8'h55, `RCT_RESP_OKAY, 1'b0);
    flashLoadValid <= 1'b1;
    @(posedge core_clk);
    flashLoadValid <= 1'b0;
    @(posedge core_clk);
    trimModel = 16'hF3FF;
    chk("trimReady", 1'b1, trimReady);
    rd(`RCT_ADDR_TRIM_HIGH, 8'hF3, `RCT_RESP_OKAY);
    rd(`RCT_ADDR_TRIM_LOW, 8'hFF, `RCT_RESP_OKAY);
    foreach (rows[i]) begin
      wr(rows[i][31:18], rows[i][17:10], rows[i][1:0], rows[i][1:0] == `RCT_RESP_OKAY);
      rd(rows[i][31:18], rows[i][9:2], rows[i][1:0]);
    end
    for (int c = 0; c < 16; c++) begin
      code = c[3:0];
      wr(`RCT_ADDR_TRIM_HIGH, {code, 4'h0}, `RCT_RESP_OKAY, 1'b1);
      chk("tcEnable", code[2:0] != 3'h0, tcCtrl.enable);
      if (code[2:0] != 3'h0) begin
        chk("tcNegative", !code[3], tcCtrl.negative);
        chk("tcStep", code[2:0], tcCtrl.step);
      end
    end
    // Protected write with the PLL selected must change nothing and clear nothing
    clockConfigProtect <= 1'b1;
    pllClockSelect <= 1'b1;
    wr(`RCT_ADDR_TRIM_LOW, 8'h5A, `RCT_RESP_OKAY, 1'b0);
    // Software has unlocked protection before these writes
    clockConfigProtect <= 1'b0;
    wr(`RCT_ADDR_TRIM_LOW, 8'hA5, `RCT_RESP_OKAY, 1'b1);
    wr(`RCT_ADDR_TRIM_HIGH, 8'h9E, `RCT_RESP_OKAY, 1'b1);
    pllClockSelect <= 1'b0;
    wr(`RCT_ADDR_TRIM_LOW, 8'h3C, `RCT_RESP_OKAY, 1'b1);
    rd(`RCT_ADDR_TRIM_HIGH, 8'h92, `RCT_RESP_OKAY);
    // Second reset drops the trim until the next factory load
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk("trimReady", 1'b0, trimReady);
    chk("tempcoTrim", 4'h0, tempcoTrim);
    // Release again: the factory load must run a second time
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    flashLoadValid <= 1'b1;
    @(posedge core_clk);
    flashLoadValid <= 1'b0;
    @(posedge core_clk);
    chk("trimReady", 1'b1, trimReady);
    chk("tempcoTrim", 4'hF, tempcoTrim);
    close_out();
  end

  initial begin
    repeat (6000) @(posedge core_clk);
    miscompares++;
    close_out();
  end
endmodule
